// ### tsc_core.sv
/*
  Register and conversion control core of a two-wire temperature sensor:
  index register, temperature, mode control and limit registers, the
  conversion sequencer and the limit checking.
  Assumes a bus front end on the same clock that hands over whole bytes,
  and a converter on the same clock that supplies a sample and a strobe.
*/
// Summary of operation
// - Eight-bit index, low two bits select register
// - Select 0 temp, 1 mode, 2 lower, 3 upper
// - Select resets to zero, temperature read default
// - Read-only temperature, 12 or 13 bits wide
// - Temperature read high byte first, low optional
// - Left-justified two's complement, 0.0625 C steps
// - Temperature reads zero until first conversion
// - Low byte bit 0 shows wide format
// - Unused temperature bits read zero
// - Bit layout per format across two bytes
// - Sixteen-bit registers, high byte first, bytewise update
// - Mode control field layout and reset values
// - Wide select sets format of all three
// - Threshold flag follows limit crossings with faults
// - Inversion flips flag, thermostat kind does not
// - Rate select gives 0.25, 1, 4, 8 Hz
// - One conversion then idle for period rest
// - Conversion starts at once after any reset
// - Power-down finishes conversion then shuts down
// - Thermostat kind: comparator or interrupt behaviour
// - Fault select needs 1, 2, 4, 6 faults
// - Single shot converts once while shut down
// - Resolution field always reads binary 11
// - Interrupt alert held until read, answer, shutdown
`timescale 1ns/1ps
module tsc_core #(
  parameter int CONV_CYC  = tsc_pkg::CONV_CYC,
  parameter int PER_CYC_0 = tsc_pkg::PERIOD_CYC_R0,
  parameter int PER_CYC_1 = tsc_pkg::PERIOD_CYC_R1,
  parameter int PER_CYC_2 = tsc_pkg::PERIOD_CYC_R2,
  parameter int PER_CYC_3 = tsc_pkg::PERIOD_CYC_R3
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Byte side of the bus front end
  input  wire logic        xfer_start,
  input  wire logic        index_wr,
  input  wire logic        data_wr,
  input  wire logic [7:0]  wr_byte,
  input  wire logic        rd_req,
  output logic [7:0]       rd_byte,
  output logic             rd_valid,
  // Bus events
  input  wire logic        gc_reset,
  input  wire logic        ara_ack,
  // Converter
  input  wire logic [12:0] adc_sample,
  input  wire logic        adc_done,
  output logic             adc_start,
  // Status
  output logic             alert_active,
  output logic             conv_busy
);
  if (CONV_CYC < 2 || PER_CYC_3 <= CONV_CYC + 2 ||
      PER_CYC_2 <= CONV_CYC + 2 || PER_CYC_1 <= CONV_CYC + 2 ||
      PER_CYC_0 <= CONV_CYC + 2) begin : g_bad_cyc
    $error("tsc_core: period must exceed conversion time");
  end

  typedef struct packed {
    logic [7:0]           idx;
    logic                 pos;
    logic [12:0]          temp;
    logic [12:0]          sample;
    logic                 os;
    logic                 oneshot;
    logic [1:0]           fault;
    logic                 inv;
    logic                 tk;
    logic                 pd;
    logic [1:0]           rate;
    logic                 em;
    logic [15:0]          lower;
    logic [15:0]          upper;
    logic                 comp;
    logic                 intal;
    logic                 started;
    tsc_pkg::tsc_conv_st_t st;
    logic [7:0]           rd_byte;
    logic                 rd_valid;
    logic                 adc_start;
    logic                 alert;
    logic                 busy;
  } tsc_core_state_t;

  localparam tsc_core_state_t RST = '{
    idx: tsc_pkg::IDX_RST, pos: 1'b0, temp: 13'h0000, sample: 13'h0000,
    os: 1'b0, oneshot: 1'b0, fault: tsc_pkg::FAULT_RST, inv: 1'b0,
    tk: 1'b0, pd: 1'b0, rate: tsc_pkg::RATE_RST, em: 1'b0,
    lower: tsc_pkg::LOWER_RST, upper: tsc_pkg::UPPER_RST, comp: 1'b0,
    intal: 1'b0, started: 1'b0, st: tsc_pkg::ST_SHUT, rd_byte: 8'h00,
    rd_valid: 1'b0, adc_start: 1'b0, alert: 1'b0, busy: 1'b0};

  tsc_core_state_t q, d;

  logic [1:0]         sel;
  logic               flag;
  logic [15:0]        word;
  logic [15:0]        lim_mask;
  logic signed [12:0] new_t;
  logic signed [12:0] up_v;
  logic signed [12:0] lo_v;
  logic [2:0]         need;
  logic [31:0]        tmr_val;
  logic [31:0]        idle_cyc;
  logic               tmr_load;
  logic               tmr_exp;
  logic               res_stb;
  logic               hi_hit;
  logic               lo_hit;
  logic               ev;
  logic               shut_enter;

  // Limit register value at the active width
  function automatic logic signed [12:0] lim_val(input logic [15:0] w,
                                                 input logic em);
    lim_val = em ? $signed(w[15:3]) : $signed({w[15], w[15:4]});
  endfunction : lim_val

  // Converter result narrowed to the active range
  function automatic logic signed [12:0] clamp(input logic [12:0] s,
                                               input logic em);
    logic signed [12:0] v;
    v = $signed(s);
    if (em) begin
      clamp = v;
    end else if (v > tsc_pkg::T12_MAX) begin
      clamp = tsc_pkg::T12_MAX;
    end else if (v < tsc_pkg::T12_MIN) begin
      clamp = tsc_pkg::T12_MIN;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  assign sel      = q.idx[1:0];
  assign flag     = ~q.comp ^ q.inv;
  assign lim_mask = q.em ? 16'hfff8 : 16'hfff0;
  assign new_t    = clamp(q.sample, q.em);
  assign up_v     = lim_val(q.upper, q.em);
  assign lo_v     = lim_val(q.lower, q.em);

  always_comb begin
    case (q.fault)
      2'h0:    need = tsc_pkg::FAULTS_0;
      2'h1:    need = tsc_pkg::FAULTS_1;
      2'h2:    need = tsc_pkg::FAULTS_2;
      default: need = tsc_pkg::FAULTS_3;
    endcase
    // Timer load and expiry cost two cycles of each period
    case (q.rate)
      2'h0:    idle_cyc = 32'(PER_CYC_0 - CONV_CYC - 2);
      2'h1:    idle_cyc = 32'(PER_CYC_1 - CONV_CYC - 2);
      2'h2:    idle_cyc = 32'(PER_CYC_2 - CONV_CYC - 2);
      default: idle_cyc = 32'(PER_CYC_3 - CONV_CYC - 2);
    endcase
  end

  // Register read view
  always_comb begin
    case (sel)
      tsc_pkg::SEL_TEMP: begin
        if (q.em) begin
          word = {q.temp, 2'h0, 1'b1};
        end else begin
          word = {q.temp[11:0], 4'h0};
        end
      end
      tsc_pkg::SEL_MODE: begin
        word = {q.os, tsc_pkg::RESOLUTION_VAL, q.fault, q.inv, q.tk, q.pd,
                q.rate, flag, q.em, 4'h0};
      end
      tsc_pkg::SEL_LOWER: word = q.lower & lim_mask;
      default:            word = q.upper & lim_mask;
    endcase
  end

  // Comparator state changes after enough consecutive faults
  assign ev = (hi_hit && !q.comp) || (lo_hit && q.comp);

  tsc_fault_q #(
    .CW(3)
  ) u_fault_hi (
    .mclk   (mclk),
    .reset  (reset),
    .clear  (ev || gc_reset),
    .sample (res_stb),
    .cond   (new_t >= up_v),
    .need   (need),
    .hit    (hi_hit)
  );

  tsc_fault_q #(
    .CW(3)
  ) u_fault_lo (
    .mclk   (mclk),
    .reset  (reset),
    .clear  (ev || gc_reset),
    .sample (res_stb),
    .cond   (new_t < lo_v),
    .need   (need),
    .hit    (lo_hit)
  );

  tsc_timer #(
    .W(32)
  ) u_timer (
    .mclk     (mclk),
    .reset    (reset),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expire   (tmr_exp)
  );

  always_comb begin
    d = q;
    d.rd_valid  = 1'b0;
    d.adc_start = 1'b0;
    tmr_load    = 1'b0;
    tmr_val     = 32'h0;
    res_stb     = 1'b0;
    shut_enter  = 1'b0;

    if (adc_done) begin
      d.sample = adc_sample;
    end

    // Byte writes, one byte at a time
    if (index_wr) begin
      d.idx = wr_byte;
      d.pos = 1'b0;
    end else if (data_wr) begin
      d.pos = ~q.pos;
      case (sel)
        tsc_pkg::SEL_MODE: begin
          if (!q.pos) begin
            d.fault = wr_byte[tsc_pkg::B1_FAULT_HI:tsc_pkg::B1_FAULT_LO];
            d.inv   = wr_byte[tsc_pkg::B1_INVERSION];
            d.tk    = wr_byte[tsc_pkg::B1_THERMO_KIND];
            d.pd    = wr_byte[tsc_pkg::B1_POWER_DOWN];
          end else begin
            d.rate = wr_byte[tsc_pkg::B2_RATE_HI:tsc_pkg::B2_RATE_LO];
            d.em   = wr_byte[tsc_pkg::B2_WIDE];
          end
        end
        tsc_pkg::SEL_LOWER: begin
          if (!q.pos) begin
            d.lower[15:8] = wr_byte;
          end else begin
            d.lower[7:0] = wr_byte;
          end
        end
        tsc_pkg::SEL_UPPER: begin
          if (!q.pos) begin
            d.upper[15:8] = wr_byte;
          end else begin
            d.upper[7:0] = wr_byte;
          end
        end
        default: d.pos = ~q.pos;
      endcase
    end

    // Byte reads, high byte first
    if (rd_req) begin
      d.rd_byte  = q.pos ? word[7:0] : word[15:8];
      d.rd_valid = 1'b1;
      d.pos      = ~q.pos;
    end
    if (xfer_start) begin
      d.pos = 1'b0;
    end

    // Conversion sequencer
    if (!q.started) begin
      d.started   = 1'b1;
      d.st        = tsc_pkg::ST_CONV;
      d.adc_start = 1'b1;
      tmr_load    = 1'b1;
      tmr_val     = 32'(CONV_CYC);
    end else begin
      case (q.st)
        tsc_pkg::ST_CONV: begin
          if (tmr_exp) begin
            d.temp  = new_t;
            res_stb = 1'b1;
            if (q.pd || q.oneshot) begin
              d.st       = tsc_pkg::ST_SHUT;
              shut_enter = q.pd;
              tmr_load   = 1'b1;
              if (q.oneshot) begin
                d.os      = 1'b1;
                d.oneshot = 1'b0;
              end
            end else begin
              d.st     = tsc_pkg::ST_WAIT;
              tmr_load = 1'b1;
              tmr_val  = idle_cyc;
            end
          end
        end
        tsc_pkg::ST_WAIT: begin
          if (q.pd) begin
            d.st       = tsc_pkg::ST_SHUT;
            shut_enter = 1'b1;
            tmr_load   = 1'b1;
          end else if (tmr_exp) begin
            d.st        = tsc_pkg::ST_CONV;
            d.adc_start = 1'b1;
            tmr_load    = 1'b1;
            tmr_val     = 32'(CONV_CYC);
          end
        end
        tsc_pkg::ST_SHUT: begin
          if (data_wr && sel == tsc_pkg::SEL_MODE && !q.pos &&
              wr_byte[tsc_pkg::B1_SINGLE_SHOT]) begin
            d.st        = tsc_pkg::ST_CONV;
            d.oneshot   = 1'b1;
            d.os        = 1'b0;
            d.adc_start = 1'b1;
            tmr_load    = 1'b1;
            tmr_val     = 32'(CONV_CYC);
          end else if (!q.pd) begin
            d.st        = tsc_pkg::ST_CONV;
            d.adc_start = 1'b1;
            tmr_load    = 1'b1;
            tmr_val     = 32'(CONV_CYC);
          end
        end
        default: d.st = tsc_pkg::ST_SHUT;
      endcase
    end

    // Limit state and alert
    if (ev) begin
      d.comp = ~q.comp;
    end
    if (rd_req || ara_ack || shut_enter) begin
      d.intal = 1'b0;
    end
    if (ev) begin
      d.intal = 1'b1;
    end
    d.alert = d.tk ? d.intal : d.comp;
    d.busy  = (d.st == tsc_pkg::ST_CONV);

    if (gc_reset) begin
      d = RST;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign rd_byte      = q.rd_byte;
  assign rd_valid     = q.rd_valid;
  assign adc_start    = q.adc_start;
  assign alert_active = q.alert;
  assign conv_busy    = q.busy;

  // Checks
  a_index_select: assert property (@(posedge mclk) disable iff (reset)
    index_wr && !gc_reset |=> sel == $past(wr_byte[1:0]))
    else $error("index select not taken from written byte");

  a_temp_readonly: assert property (@(posedge mclk) disable iff (reset)
    data_wr && sel == tsc_pkg::SEL_TEMP && !res_stb && !gc_reset
    |=> $stable(q.temp))
    else $error("temperature changed by a write");

  a_format_bit: assert property (@(posedge mclk) disable iff (reset)
    rd_req && sel == tsc_pkg::SEL_TEMP && q.pos && !gc_reset
    |=> rd_byte[0] == $past(q.em))
    else $error("format bit does not follow wide select");

  a_unused_zero: assert property (@(posedge mclk) disable iff (reset)
    rd_req && sel == tsc_pkg::SEL_TEMP && q.pos && !q.em && !gc_reset
    |=> rd_byte[3:0] == 4'h0)
    else $error("unused temperature bits not zero");

  a_resolution: assert property (@(posedge mclk) disable iff (reset)
    rd_req && sel == tsc_pkg::SEL_MODE && !q.pos && !gc_reset
    |=> rd_byte[6:5] == tsc_pkg::RESOLUTION_VAL)
    else $error("resolution field not fixed");

  a_flag_view: assert property (@(posedge mclk) disable iff (reset)
    rd_req && sel == tsc_pkg::SEL_MODE && q.pos && !gc_reset
    |=> rd_byte[5] == ($past(q.inv) ^ ~$past(q.comp)))
    else $error("threshold flag view wrong");

  a_power_down: assert property (@(posedge mclk) disable iff (reset)
    q.started && q.st == tsc_pkg::ST_WAIT && q.pd && !gc_reset
    |=> q.st == tsc_pkg::ST_SHUT && !adc_start)
    else $error("power down not entered from idle");

  a_gc_start: assert property (@(posedge mclk) disable iff (reset)
    gc_reset |=> ##1 q.st == tsc_pkg::ST_CONV && adc_start)
    else $error("no conversion after general reset");

  a_shot_busy: assert property (@(posedge mclk) disable iff (reset)
    q.oneshot |-> !q.os && q.st == tsc_pkg::ST_CONV)
    else $error("single shot bit high during conversion");

  a_int_clear: assert property (@(posedge mclk) disable iff (reset)
    q.tk && rd_req && !ev && !gc_reset |=> !alert_active)
    else $error("interrupt alert not cleared by read");

endmodule : tsc_core

// ### tsc_pkg.sv
/*
  Shared constants and types of the temperature sensor register core:
  register select codes, mode control field positions, reset values and
  conversion timing.
  Assumes a single 100 MHz clock.
*/
package tsc_pkg;

  // Clock and conversion timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int CONV_TIME_MS = 26;
  localparam int CONV_CYC     = CONV_TIME_MS * CYC_PER_MS;
  localparam int PERIOD_MS_R0 = 4000;
  localparam int PERIOD_MS_R1 = 1000;
  localparam int PERIOD_MS_R2 = 250;
  localparam int PERIOD_MS_R3 = 125;
  localparam int PERIOD_CYC_R0 = PERIOD_MS_R0 * CYC_PER_MS;
  localparam int PERIOD_CYC_R1 = PERIOD_MS_R1 * CYC_PER_MS;
  localparam int PERIOD_CYC_R2 = PERIOD_MS_R2 * CYC_PER_MS;
  localparam int PERIOD_CYC_R3 = PERIOD_MS_R3 * CYC_PER_MS;

  // Register select codes
  localparam logic [1:0] SEL_TEMP  = 2'h0;
  localparam logic [1:0] SEL_MODE  = 2'h1;
  localparam logic [1:0] SEL_LOWER = 2'h2;
  localparam logic [1:0] SEL_UPPER = 2'h3;

  // Mode control byte one positions
  localparam int B1_SINGLE_SHOT = 7;
  localparam int B1_FAULT_HI    = 4;
  localparam int B1_FAULT_LO    = 3;
  localparam int B1_INVERSION   = 2;
  localparam int B1_THERMO_KIND = 1;
  localparam int B1_POWER_DOWN  = 0;
  // Mode control byte two positions
  localparam int B2_RATE_HI     = 7;
  localparam int B2_RATE_LO     = 6;
  localparam int B2_FLAG        = 5;
  localparam int B2_WIDE        = 4;

  // Reset values
  localparam logic [7:0]  IDX_RST        = 8'h00;
  localparam logic [1:0]  RESOLUTION_VAL = 2'h3;
  localparam logic [1:0]  FAULT_RST      = 2'h0;
  localparam logic [1:0]  RATE_RST       = 2'h2;
  localparam logic [15:0] LOWER_RST      = 16'h4b00;
  localparam logic [15:0] UPPER_RST      = 16'h5000;

  // Consecutive fault counts
  localparam logic [2:0] FAULTS_0 = 3'h1;
  localparam logic [2:0] FAULTS_1 = 3'h2;
  localparam logic [2:0] FAULTS_2 = 3'h4;
  localparam logic [2:0] FAULTS_3 = 3'h6;

  // Limits of the 12-bit format inside the 13-bit value
  localparam logic signed [12:0] T12_MAX = 13'sh07ff;
  localparam logic signed [12:0] T12_MIN = 13'sh1800;

  typedef enum logic [1:0] {ST_SHUT, ST_CONV, ST_WAIT} tsc_conv_st_t;

endpackage : tsc_pkg

// ### tsc_timer.sv
/*
  Loadable down counter for conversion and idle intervals.
  Assumes load comes from logic on the same clock.
*/
`timescale 1ns/1ps
module tsc_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              expire
);
  if (W < 2) begin : g_bad_w
    $error("tsc_timer: W too small");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } tsc_timer_state_t;

  tsc_timer_state_t q, d;

  always_comb begin
    d = q;
    d.exp = 1'b0;
    if (load) begin
      d.cnt = load_val;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      d.exp = (q.cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.exp;

endmodule : tsc_timer

// ### tsc_fault_q.sv
/*
  Consecutive fault counter: counts conversions in a row that meet a
  condition and pulses when the required number is reached.
  Assumes sample pulses once per completed conversion.
*/
`timescale 1ns/1ps
module tsc_fault_q #(
  parameter int CW = 3
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // Conversion results
  input  wire logic          clear,
  input  wire logic          sample,
  input  wire logic          cond,
  input  wire logic [CW-1:0] need,
  // Result
  output logic               hit
);
  if (CW < 3) begin : g_bad_cw
    $error("tsc_fault_q: CW cannot hold six faults");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          hit;
  } tsc_fault_state_t;

  tsc_fault_state_t q, d;
  logic [CW-1:0]    nxt;

  always_comb begin
    d = q;
    d.hit = 1'b0;
    nxt = (q.cnt == '1) ? q.cnt : q.cnt + 1'b1;
    if (clear) begin
      d.cnt = '0;
    end else if (sample) begin
      if (cond) begin
        d.cnt = nxt;
        d.hit = (nxt >= need);
      end else begin
        d.cnt = '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hit = q.hit;

endmodule : tsc_fault_q

// ### tsc_master_model.sv
/*
  Bus master model: byte-level index, data write and read cycles.
  Assumes the core samples its byte side on the rising edge of mclk.
*/
`timescale 1ns/1ps
module tsc_master_model (
  // Clock
  input  wire logic       mclk,
  // Byte side
  output logic            xfer_start,
  output logic            index_wr,
  output logic            data_wr,
  output logic [7:0]      wr_byte,
  output logic            rd_req,
  input  wire logic [7:0] rd_byte,
  input  wire logic       rd_valid
);
  initial begin
    xfer_start = 1'b0;
    index_wr   = 1'b0;
    data_wr    = 1'b0;
    wr_byte    = 8'h00;
    rd_req     = 1'b0;
  end

  task start();
    @(posedge mclk);
    xfer_start <= 1'b1;
    @(posedge mclk);
    xfer_start <= 1'b0;
  endtask : start

  task put_index(input logic [1:0] sel);
    @(posedge mclk);
    index_wr <= 1'b1;
    wr_byte  <= {6'h00, sel};
    @(posedge mclk);
    index_wr <= 1'b0;
    // Released data shows garbage, not the last byte
    wr_byte  <= ~wr_byte;
  endtask : put_index

  task put_byte(input logic [7:0] b);
    @(posedge mclk);
    data_wr <= 1'b1;
    wr_byte <= b;
    @(posedge mclk);
    data_wr <= 1'b0;
    wr_byte <= ~b;
  endtask : put_byte

  task get_byte(output logic [7:0] b, output logic v);
    @(posedge mclk);
    rd_req <= 1'b1;
    @(posedge mclk);
    rd_req <= 1'b0;
    #1;
    b = rd_byte;
    v = rd_valid;
  endtask : get_byte
endmodule : tsc_master_model

// ### tsc_core_tb_top.sv
/*
  Testbench of the register core: register reads and writes through the
  master model, a converter model, rate, shutdown and reset checks.
  Assumes tsc_pkg, tsc_core and tsc_master_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED t=%0t got %0h want %0h", $time, a, e); \
    end \
  end
module tsc_core_tb_top;
  localparam int CONV   = 20;
  localparam int PER[4] = '{200, 100, 60, 40};

  logic        mclk       = 1'b0;
  logic        reset      = 1'b1;
  logic        gc_reset   = 1'b0;
  logic        ara_ack    = 1'b0;
  logic [12:0] adc_sample = 13'h0000;
  logic        adc_done   = 1'b0;
  logic [12:0] temp_in    = 13'h0190;
  logic        xfer_start, index_wr, data_wr, rd_req;
  logic        rd_valid, adc_start, alert_active, conv_busy;
  logic [7:0]  wr_byte, rd_byte;
  int          errors  = 0;
  int          checked = 0;
  int          cdly    = 0;
  int          n_start = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end

  tsc_core #(
    .CONV_CYC (CONV),
    .PER_CYC_0(PER[0]),
    .PER_CYC_1(PER[1]),
    .PER_CYC_2(PER[2]),
    .PER_CYC_3(PER[3])
  ) u_tsc_core (
    .mclk(mclk), .reset(reset), .xfer_start(xfer_start),
    .index_wr(index_wr), .data_wr(data_wr), .wr_byte(wr_byte),
    .rd_req(rd_req), .rd_byte(rd_byte), .rd_valid(rd_valid),
    .gc_reset(gc_reset), .ara_ack(ara_ack), .adc_sample(adc_sample),
    .adc_done(adc_done), .adc_start(adc_start),
    .alert_active(alert_active), .conv_busy(conv_busy)
  );

  tsc_master_model u_tsc_master_model (
    .mclk(mclk), .xfer_start(xfer_start), .index_wr(index_wr),
    .data_wr(data_wr), .wr_byte(wr_byte), .rd_req(rd_req),
    .rd_byte(rd_byte), .rd_valid(rd_valid)
  );

  // Converter: sample valid only in the strobe cycle
  always @(posedge mclk) begin
    adc_done   <= 1'b0;
    adc_sample <= ~temp_in;
    if (adc_start === 1'b1) begin
      cdly = 5;
    end else if (cdly > 0) begin
      cdly = cdly - 1;
      if (cdly == 0) begin
        adc_done   <= 1'b1;
        adc_sample <= temp_in;
      end
    end
    if (adc_start === 1'b1) begin
      n_start++;
    end
  end

  task results();
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task chk16(input logic ix, input logic [1:0] s, input logic [15:0] e);
    logic [7:0] h, l;
    logic       vh, vl;
    if (ix) begin
      u_tsc_master_model.put_index(s);
    end else begin
      u_tsc_master_model.start();
    end
    u_tsc_master_model.get_byte(h, vh);
    u_tsc_master_model.get_byte(l, vl);
    `CHK({vh, vl, h, l}, {2'h3, e})
  endtask : chk16

  task chk8(input logic [1:0] s, input logic [7:0] e);
    logic [7:0] h;
    logic       vh;
    u_tsc_master_model.put_index(s);
    u_tsc_master_model.get_byte(h, vh);
    `CHK({vh, h}, {1'b1, e})
  endtask : chk8

  task wr16(input logic [1:0] s, input logic [15:0] w);
    u_tsc_master_model.put_index(s);
    u_tsc_master_model.put_byte(w[15:8]);
    u_tsc_master_model.put_byte(w[7:0]);
  endtask : wr16

  task wr1(input logic [1:0] s, input logic [7:0] b);
    u_tsc_master_model.put_index(s);
    u_tsc_master_model.put_byte(b);
  endtask : wr1

  // Cycles until the next conversion start, bounded
  task next_start(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (adc_start !== 1'b1 && n < 1000);
  endtask : next_start

  task conv();
    int n;
    next_start(n);
    repeat (CONV + 6) @(posedge mclk);
  endtask : conv

  initial begin
    int n, m;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    chk16(1'b0, tsc_pkg::SEL_TEMP, 16'h0000);
    chk16(1'b1, tsc_pkg::SEL_MODE, 16'h60a0);
    chk16(1'b1, tsc_pkg::SEL_LOWER, 16'h4b00);
    chk16(1'b1, tsc_pkg::SEL_UPPER, 16'h5000);
    conv();
    chk16(1'b1, tsc_pkg::SEL_TEMP, 16'h1900);
    wr16(tsc_pkg::SEL_MODE, 16'h0090);
    chk16(1'b1, tsc_pkg::SEL_MODE, 16'h60b0);
    // Exactly the upper limit in wide format
    temp_in = 13'h0a00;
    conv();
    chk16(1'b1, tsc_pkg::SEL_TEMP, 16'h5001);
    chk16(1'b1, tsc_pkg::SEL_MODE, 16'h6090);
    wr1(tsc_pkg::SEL_MODE, 8'h04);
    chk16(1'b1, tsc_pkg::SEL_MODE, 16'h64b0);
    `CHK(alert_active, 1'b1)
    wr16(tsc_pkg::SEL_LOWER, 16'h123f);
    chk16(1'b1, tsc_pkg::SEL_LOWER, 16'h1238);
    wr1(tsc_pkg::SEL_TEMP, 8'hff);
    chk16(1'b1, tsc_pkg::SEL_TEMP, 16'h5001);
    // Interrupt behaviour: fall below the lower limit, then rise again
    wr1(tsc_pkg::SEL_MODE, 8'h06);
    temp_in = 13'h1e70;
    conv();
    `CHK(alert_active, 1'b1)
    @(posedge mclk);
    ara_ack <= 1'b1;
    @(posedge mclk);
    ara_ack <= 1'b0;
    #1;
    `CHK(alert_active, 1'b0)
    chk16(1'b1, tsc_pkg::SEL_TEMP, 16'hf381);
    temp_in = 13'h0a00;
    conv();
    `CHK(alert_active, 1'b1)
    chk8(tsc_pkg::SEL_MODE, 8'h66);
    `CHK(alert_active, 1'b0)
    for (int r = 0; r < 4; r++) begin
      wr16(tsc_pkg::SEL_MODE, {8'h00, r[1:0], 6'h00});
      next_start(n);
      next_start(n);
      next_start(n);
      `CHK(n, PER[r])
    end
    wr1(tsc_pkg::SEL_MODE, 8'h01);
    repeat (CONV + 6) @(posedge mclk);
    m = n_start;
    repeat (300) @(posedge mclk);
    `CHK({n_start - m, conv_busy}, {32'd0, 1'b0})
    wr1(tsc_pkg::SEL_MODE, 8'h81);
    chk8(tsc_pkg::SEL_MODE, 8'h61);
    repeat (CONV + 6) @(posedge mclk);
    chk8(tsc_pkg::SEL_MODE, 8'he1);
    @(posedge mclk);
    gc_reset <= 1'b1;
    @(posedge mclk);
    gc_reset <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(adc_start, 1'b1)
    chk16(1'b0, tsc_pkg::SEL_TEMP, 16'h0000);
    chk16(1'b1, tsc_pkg::SEL_MODE, 16'h60a0);
    results();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end
endmodule : tsc_core_tb_top
